/* File: srfs_device.sv */
// srfs_device.sv: device end, decodes refresh, runs internal row counter
// assumes controller keeps precharge and deselect timing; one clock, async reset
//
// How it works
// - refresh on cs ras cas low, we high
// - controller precharges all banks before refresh; here it issues no precharge and forced refreshes ignore idle_i
// - rows counted internally, address pins ignored
// - banks left precharged idle after refresh
// - only deselect until refresh cycle time
// - one command per refresh, average interval
// - postpone at most 8/16/32 refreshes
// - gap at most 9/17/33 intervals
// - pull in at most 8/16/32 refreshes
// - each early refresh cancels one later
// - burst limits on extra 2x/4x refreshes
// - tcr off: 3.9us hot, 7.8us cool
// - mode four bit3 enables temperature refresh
// - mode four bit2 selects extended range
// - tcr on: accept all, skip some internally
// - normal range: may skip below 45C
// - extended range: skip to normal interval
// - extended range needs 3.9us external period
// - mode three bits 8:6 select refresh rate; here they only reach rate_o, interval and cycle time ignore them
`timescale 1ns/1ps
`include "srfs_consts.svh"
module srfs_device
  import srfs_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset, high
  srfs_if.dev bus, // command pins
  input wire logic [7:0] temp_i, // case temperature in C
  output logic busy_o, // refresh cycle running
  output logic banks_idle_o, // all banks precharged
  output logic [`SRFS_ROW_W-1:0] row_o, // next internal refresh row
  output logic skipped_o, // last command was skipped
  output logic [2:0] rate_o // active rate code
);
  srfs_dev_state_t state_q;
  logic [8:0] cnt_q;
  logic [1:0] gear_q;
  logic ref_cmd;
  logic take;
  logic skip;
  logic tcr_en;
  logic tcr_ext;
  logic [8:0] rfc_cyc;

  // command decode on rising edge
  assign ref_cmd = !bus.cs_n && !bus.ras_n && !bus.cas_n && bus.we_n;
  // a refresh spaced one cycle past the cycle time lands in the done cycle, so take it there too
  assign take = ref_cmd && (state_q != SRFS_DV_REF);
  assign tcr_en = bus.mode_register_four[`SRFS_MR4_TCR_EN_BIT];
  assign tcr_ext = bus.mode_register_four[`SRFS_MR4_TCR_RANGE_BIT];
  assign rfc_cyc = 9'(`SRFS_RFC_CYC);

  // skip decision: extended range halves below 85C, cool quarters
  always_comb begin
    skip = 1'b0;
    if (tcr_en) begin
      if (tcr_ext && temp_i < `SRFS_HOT_85C) begin
        skip = (temp_i < `SRFS_COOL_45C) ? (gear_q != 2'd0) : gear_q[0];
      end else if (!tcr_ext && temp_i < `SRFS_COOL_45C) begin
        skip = gear_q[0];
      end
    end
  end

  // refresh state machine, waits refresh cycle time
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SRFS_DV_IDLE;
      cnt_q <= 9'd0;
    end else begin
      unique case (state_q)
        SRFS_DV_IDLE: begin
          if (take) begin
            state_q <= SRFS_DV_REF;
            cnt_q <= rfc_cyc - 9'd1;
          end
        end
        SRFS_DV_REF: begin
          if (cnt_q == 9'd0) begin
            state_q <= SRFS_DV_DONE;
          end else begin
            cnt_q <= cnt_q - 9'd1;
          end
        end
        SRFS_DV_DONE: begin
          if (take) begin
            state_q <= SRFS_DV_REF;
            cnt_q <= rfc_cyc - 9'd1;
          end else begin
            state_q <= SRFS_DV_IDLE;
          end
        end
        default: state_q <= SRFS_DV_IDLE;
      endcase
    end
  end

  // internal row counter, address pins unused
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      row_o <= '0;
      gear_q <= 2'd0;
      skipped_o <= 1'b0;
    end else if (take) begin
      gear_q <= gear_q + 2'd1;
      skipped_o <= skip;
      if (!skip) begin
        row_o <= row_o + 1'b1;
      end
    end
  end

  // latched rate mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rate_o <= 3'b000;
    end else begin
      rate_o <= bus.mode_register_three[`SRFS_MR3_RATE_HI:`SRFS_MR3_RATE_LO];
    end
  end

  assign busy_o = (state_q == SRFS_DV_REF);
  assign banks_idle_o = (state_q != SRFS_DV_REF);
endmodule

/* File: srfs_consts.svh */
// srfs_consts.svh: clock period, mode fields, timing counts for the refresh pair
// assumes a 50 MHz clock (20 ns period)
`ifndef SRFS_CONSTS_SVH
`define SRFS_CONSTS_SVH
`define SRFS_CLK_NS 20
`define SRFS_RFC_NS 350
`define SRFS_RFC_CYC ((`SRFS_RFC_NS + `SRFS_CLK_NS - 1) / `SRFS_CLK_NS)
`define SRFS_RP_NS 15
`define SRFS_RP_CYC ((`SRFS_RP_NS + `SRFS_CLK_NS - 1) / `SRFS_CLK_NS)
`define SRFS_REFI_BASE_NS 7800
`define SRFS_REFI_HOT_NS 3900
`define SRFS_REFI_BASE_CYC (`SRFS_REFI_BASE_NS / `SRFS_CLK_NS)
`define SRFS_REFI_HOT_CYC (`SRFS_REFI_HOT_NS / `SRFS_CLK_NS)
`define SRFS_MR4_TCR_EN_BIT 3
`define SRFS_MR4_TCR_RANGE_BIT 2
`define SRFS_MR3_RATE_HI 8
`define SRFS_MR3_RATE_LO 6
`define SRFS_POSTPONE_1X 8
`define SRFS_PULLIN_1X 8
`define SRFS_ROW_W 16
`define SRFS_COOL_45C 8'h2D
`define SRFS_HOT_85C 8'h55
`endif

/* File: srfs_pkg.sv */
// srfs_pkg.sv: shared types for the refresh pair
// assumes srfs_consts.svh is compiled alongside
package srfs_pkg;
  typedef enum logic [2:0] {
    SRFS_RATE_1X = 3'b000,
    SRFS_RATE_2X = 3'b001,
    SRFS_RATE_4X = 3'b010,
    SRFS_RATE_OTF12 = 3'b101,
    SRFS_RATE_OTF14 = 3'b110
  } srfs_rate_t;
  typedef enum logic [2:0] {
    SRFS_DV_IDLE = 3'b001,
    SRFS_DV_REF = 3'b010,
    SRFS_DV_DONE = 3'b100
  } srfs_dev_state_t;
endpackage

/* File: srfs_if.sv */
// srfs_if.sv: command pins between controller and device
// assumes one shared clock, commands sampled on its rising edge
`timescale 1ns/1ps
interface srfs_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [15:0] addr;
  logic [13:0] mode_register_four;
  logic [13:0] mode_register_three;
  modport ctrl (output cs_n, ras_n, cas_n, we_n, addr, mode_register_four, mode_register_three);
  modport dev (input cs_n, ras_n, cas_n, we_n, addr, mode_register_four, mode_register_three);
endinterface

/* File: srfs_ctrl.sv */
// srfs_ctrl.sv: controller end, schedules refresh with signed credit
// assumes banks already precharged when idle_i allows refresh
`timescale 1ns/1ps
`include "srfs_consts.svh"
module srfs_ctrl
  import srfs_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset, high
  srfs_if.ctrl bus, // command pins
  input wire logic hot_i, // case at or above 85C
  input wire logic tcr_en_i, // enable temperature refresh
  input wire logic tcr_ext_i, // extended range
  input wire logic [2:0] rate_i, // refresh rate code
  input wire logic idle_i, // user grants refresh slot
  output logic issued_o, // refresh issued this cycle
  output logic signed [5:0] credit_o // owed refreshes
);
  logic [12:0] tick_q;
  logic [8:0] lock_q;
  logic [3:0] rp_q;
  logic [12:0] refi;
  logic [15:0] gap_q;
  logic go;

  // interval: 3.9us when hot or extended tcr range
  assign refi = (hot_i || (tcr_en_i && tcr_ext_i)) ? 13'(`SRFS_REFI_HOT_CYC)
              : 13'(`SRFS_REFI_BASE_CYC);
  // forced when 8 are owed or when the gap nears its limit, whatever the idle grant says;
  // pull in only after banks sat idle for the precharge wait and while under the limit
  assign go = (lock_q == 9'd0) &&
    ((credit_o >= 6'sd`SRFS_POSTPONE_1X) || (gap_q >= {refi, 3'b000}) ||
     (idle_i && rp_q == 4'd0 && credit_o > -6'sd`SRFS_PULLIN_1X));

  // cycles since the last issue, so pull-ins then postponement cannot stretch the gap
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= 16'h0000;
    end else begin
      gap_q <= go ? 16'h0000 : gap_q + 16'h0001;
    end
  end

  // interval tick
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_q <= 13'd0;
    end else if (tick_q >= refi - 13'd1) begin
      tick_q <= 13'd0;
    end else begin
      tick_q <= tick_q + 13'd1;
    end
  end

  // credit counter, up on tick, down on issue
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      credit_o <= 6'sd0;
    end else begin
      credit_o <= credit_o + ((tick_q >= refi - 13'd1) ? 6'sd1 : 6'sd0)
                - (go ? 6'sd1 : 6'sd0);
    end
  end

  // lockout after refresh, and precharge wait after idle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_q <= 9'd0;
      rp_q <= 4'(`SRFS_RP_CYC);
    end else begin
      lock_q <= go ? 9'(`SRFS_RFC_CYC) : (lock_q != 9'd0 ? lock_q - 9'd1 : 9'd0);
      rp_q <= !idle_i ? 4'(`SRFS_RP_CYC) : (rp_q != 4'd0 ? rp_q - 4'd1 : 4'd0);
    end
  end

  // command pins: refresh else deselect
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus.cs_n <= 1'b1;
      bus.ras_n <= 1'b1;
      bus.cas_n <= 1'b1;
      bus.we_n <= 1'b1;
      issued_o <= 1'b0;
    end else begin
      bus.cs_n <= !go;
      bus.ras_n <= !go;
      bus.cas_n <= !go;
      bus.we_n <= 1'b1;
      issued_o <= go;
    end
  end

  assign bus.addr = 16'h0000;
  assign bus.mode_register_four = {10'h000, tcr_en_i, tcr_ext_i, 2'b00};
  assign bus.mode_register_three = {5'h00, rate_i, 6'h00};
endmodule

/* File: srfs_assertions.sv */
// srfs_assertions.sv: timing checks on the refresh command pins
// assumes it sits beside srfs_if in tb on the one shared clock
`timescale 1ns/1ps
module srfs_assertions (
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset
  input wire logic cs_n, // select
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write enable
  input wire logic [13:0] mode_register_four, // mode four
  input wire logic [13:0] mode_register_three, // mode three
  input wire logic tcr_en_i, // tcr enable
  input wire logic tcr_ext_i, // tcr range
  input wire logic [2:0] rate_i, // rate code
  input wire logic [2:0] rate_o, // device rate
  input wire logic busy_o, // refresh running
  input wire logic banks_idle_o, // banks idle
  input wire logic issued_o, // refresh issued
  input wire logic signed [5:0] credit_o // credit
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic go;
  logic [11:0] gap_q;
  // refresh command seen on the pins
  assign go = !cs_n && !ras_n && !cas_n && we_n;
  // cycles since the last refresh
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= 12'h000;
    end else begin
      gap_q <= go ? 12'h000 : gap_q + 12'h001;
    end
  end
  a_ref_starts_busy: assert property (go && !busy_o |=> busy_o) else $error("refresh not taken");
  a_busy_length: assert property ($rose(busy_o) |-> busy_o[*8] ##1 busy_o[*8]
    ##1 busy_o[*2] ##1 !busy_o) else $error("busy length wrong");
  a_only_deselect: assert property (go |=> cs_n[*8] ##1 cs_n[*8] ##1 cs_n[*2])
    else $error("command inside cycle time");
  a_idle_after_ref: assert property ($fell(busy_o) |-> banks_idle_o)
    else $error("banks not idle");
  a_issue_on_pins: assert property (issued_o == go) else $error("issue flag off pins");
  a_credit_bounds: assert property (credit_o >= -6'sd8 && credit_o <= 6'sd8)
    else $error("credit out of range");
  a_gap_limit: assert property (gap_q <= 12'hDB6) else $error("refresh gap too long");
  a_mode_bits: assert property ($stable({tcr_en_i, tcr_ext_i, rate_i})[*3] |->
    {mode_register_four[3:2], mode_register_three[8:6], rate_o} ==
    {tcr_en_i, tcr_ext_i, rate_i, rate_i}) else $error("mode bits wrong");
  cover property (go);
  cover property (credit_o == 6'sd8);
  cover property (credit_o == -6'sd8);
endmodule

/* File: srfs_tb.sv */
// srfs_tb.sv: self-checking bench joining controller and device
// assumes srfs_pkg and srfs_if are compiled first
`timescale 1ns/1ps
module tb;
  import srfs_pkg::*;
  logic clk_i, rst_i, hot_i, tcr_en_i, tcr_ext_i, idle_i, busy_o, banks_idle_o;
  logic skipped_o, issued_o;
  logic [2:0] rate_i, rate_o;
  logic [7:0] temp_i;
  logic [15:0] row_o;
  logic signed [5:0] credit_o;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  srfs_if u_srfs_if ();
  srfs_ctrl u_srfs_ctrl (.clk_i(clk_i), .rst_i(rst_i), .bus(u_srfs_if), .hot_i(hot_i),
    .tcr_en_i(tcr_en_i), .tcr_ext_i(tcr_ext_i), .rate_i(rate_i), .idle_i(idle_i),
    .issued_o(issued_o), .credit_o(credit_o));
  srfs_device u_srfs_device (.clk_i(clk_i), .rst_i(rst_i), .bus(u_srfs_if), .temp_i(temp_i),
    .busy_o(busy_o), .banks_idle_o(banks_idle_o), .row_o(row_o), .skipped_o(skipped_o),
    .rate_o(rate_o));
  srfs_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .cs_n(u_srfs_if.cs_n),
    .ras_n(u_srfs_if.ras_n), .cas_n(u_srfs_if.cas_n), .we_n(u_srfs_if.we_n),
    .mode_register_four(u_srfs_if.mode_register_four), .tcr_en_i(tcr_en_i),
    .mode_register_three(u_srfs_if.mode_register_three), .tcr_ext_i(tcr_ext_i),
    .rate_i(rate_i), .rate_o(rate_o), .busy_o(busy_o), .banks_idle_o(banks_idle_o),
    .issued_o(issued_o), .credit_o(credit_o));
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask
  // reset with a fresh set of levels, driven at the rising edge
  task automatic restart(input logic idle, hot, en, ext, input logic [2:0] r, input logic [7:0] t);
    @(posedge clk_i);
    rst_i <= 1'b1;
    {idle_i, hot_i, tcr_en_i, tcr_ext_i, rate_i, temp_i} <= {idle, hot, en, ext, r, t};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // cycles until the next issued refresh, bounded
  task automatic wait_iss(input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (issued_o !== 1'b1 && n < lim);
  endtask
  // pull in back to back until the credit floor
  task automatic test_pullin();
    int n;
    int k;
    k = 0;
    restart(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 8'h3C);
    repeat (9) begin
      wait_iss(40, n);
      if (n < 40) k++;
    end
    check(k, 8);
    check(credit_o, 16'hFFF8);
    check(row_o, 16'h0008);
    check({busy_o, banks_idle_o}, 16'h0001);
    $display("done pullin");
  endtask
  // postpone to the ceiling, then steady interval: cool, hot, extended tcr
  task automatic test_interval();
    int n;
    int iv;
    for (int i = 0; i < 3; i++) begin
      iv = (i == 0) ? 390 : 195;
      restart(1'b0, i == 1, i == 2, i == 2, 3'h0, 8'h3C);
      wait_iss(4000, n);
      check(n > 7 * iv, 1);
      wait_iss(500, n);
      check(n, iv);
    end
    $display("done interval");
  endtask
  // skip ratios with temperature refresh on
  task automatic test_skip();
    int n;
    int s;
    logic [7:0] tt[4] = '{8'h1E, 8'h3C, 8'h1E, 8'h3C};
    int ex[4] = '{2, 0, 3, 2};
    for (int i = 0; i < 4; i++) begin
      restart(1'b1, 1'b0, 1'b1, i[1], 3'h0, tt[i]);
      s = 0;
      repeat (4) begin
        wait_iss(40, n);
        repeat (3) @(negedge clk_i);
        if (skipped_o === 1'b1) s++;
      end
      check(s, ex[i]);
    end
    $display("done skip");
  endtask
  // every rate code reaches the device
  task automatic test_rate();
    logic [2:0] c[5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    for (int i = 0; i < 5; i++) begin
      restart(1'b0, 1'b0, 1'b0, 1'b0, c[i], 8'h3C);
      repeat (4) @(negedge clk_i);
      check(rate_o, c[i]);
    end
    $display("done rate");
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    {rst_i, idle_i, hot_i, tcr_en_i, tcr_ext_i, rate_i, temp_i} = {5'h10, 3'h0, 8'h3C};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    test_pullin();
    test_interval();
    test_skip();
    test_rate();
    complete_run();
  end
endmodule
